/* File: pkg/ahc_pkg.sv */
// Package for the ADC high-pass coefficient register bank.
// Assumes an 8-bit register port with a 7-bit address inside one register page.
package ahc_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Widths
   localparam int ADDR_W = 7;
   localparam int DATA_W = 8;
   localparam int COEF_W = 16;
   localparam int NUM_REGS = 8;

   ////////////////////////////////////////////////////////////////////////////////
   // Register offsets
   localparam logic [6:0] OFS_LEFT_D1_HIGH  = 7'h45;
   localparam logic [6:0] OFS_LEFT_D1_LOW   = 7'h46;
   localparam logic [6:0] OFS_RIGHT_N0_HIGH = 7'h47;
   localparam logic [6:0] OFS_RIGHT_N0_LOW  = 7'h48;
   localparam logic [6:0] OFS_RIGHT_N1_HIGH = 7'h49;
   localparam logic [6:0] OFS_RIGHT_N1_LOW  = 7'h4A;
   localparam logic [6:0] OFS_RIGHT_D1_HIGH = 7'h4B;
   localparam logic [6:0] OFS_RIGHT_D1_LOW  = 7'h4C;
   localparam logic [6:0] OFS_RSVD_FIRST    = 7'h4D;
   localparam logic [6:0] OFS_RSVD_LAST     = 7'h7F;

   ////////////////////////////////////////////////////////////////////////////////
   // Reset values, indexed from the first coefficient offset
   localparam logic [7:0] RST_LEFT_D1_HIGH  = 8'h53;
   localparam logic [7:0] RST_LEFT_D1_LOW   = 8'h7E;
   localparam logic [7:0] RST_RIGHT_N0_HIGH = 8'h39;
   localparam logic [7:0] RST_RIGHT_N0_LOW  = 8'h00;
   localparam logic [7:0] RST_RIGHT_N1_HIGH = 8'hF3;
   localparam logic [7:0] RST_RIGHT_N1_LOW  = 8'h2D;
   localparam logic [7:0] RST_RIGHT_D1_HIGH = 8'h00;
   localparam logic [7:0] RST_RIGHT_D1_LOW  = 8'h7E;
   localparam logic [7:0] RST_RSVD          = 8'h00;

   localparam logic [NUM_REGS*8-1:0] RST_TABLE = {
      RST_RIGHT_D1_LOW, RST_RIGHT_D1_HIGH, RST_RIGHT_N1_LOW, RST_RIGHT_N1_HIGH,
      RST_RIGHT_N0_LOW, RST_RIGHT_N0_HIGH, RST_LEFT_D1_LOW, RST_LEFT_D1_HIGH};

   ////////////////////////////////////////////////////////////////////////////////
   // Carriers
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [6:0] addr;
      logic [7:0] wdata;
   } ahc_req_s;

   typedef struct packed {
      logic [15:0] left_feedback_coef_one;
      logic [15:0] right_feedforward_coef_zero;
      logic [15:0] right_feedforward_coef_one;
      logic [15:0] right_feedback_coef_one;
   } ahc_coef_s;

   // Assembled coefficients after reset, high byte above low byte
   localparam ahc_coef_s COEF_RST = '{
      left_feedback_coef_one:      {RST_LEFT_D1_HIGH, RST_LEFT_D1_LOW},
      right_feedforward_coef_zero: {RST_RIGHT_N0_HIGH, RST_RIGHT_N0_LOW},
      right_feedforward_coef_one:  {RST_RIGHT_N1_HIGH, RST_RIGHT_N1_LOW},
      right_feedback_coef_one:     {RST_RIGHT_D1_HIGH, RST_RIGHT_D1_LOW}};

endpackage : ahc_pkg

/* File: rtl/ahc_byte_reg.sv */
// One 8-bit read/write coefficient byte with a fixed reset value.
// Assumes a synchronous active-high reset on the same clock.
`timescale 1ns/1ps
module ahc_byte_reg #(
   parameter logic [7:0] RESET_VAL = 8'h00
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Write port
   input  wire logic       wr_en,
   input  wire logic [7:0] wdata,
   // Stored byte
   output logic      [7:0] q
);
   ////////////////////////////////////////////////////////////////////////////////
   // Storage: reset value loads on rst, otherwise the write lands
   always_ff @(posedge clk) begin
      if (rst) begin
         q <= RESET_VAL;
      end else if (wr_en) begin
         q <= wdata;
      end
   end
endmodule : ahc_byte_reg

/* File: rtl/ahc_coef_regs.sv */
// Register bank for the ADC high-pass filter coefficients of one register page.
// Operation
// [R1] Each high/low byte pair forms one 16-bit two's-complement coefficient.
// [R2] Left feedback coefficient one resets to high 0x53, low 0x7E.
// [R3] Right feedforward coefficient zero high byte resets to 0x39, read/write.
// [R4] Right feedforward coefficient one resets to 0xF3 high, 0x2D low, read/write.
// [R5] Right feedback coefficient one low byte resets to 0x7E, read/write.
// [R6] Addresses 77 to 127 are read-only zero; the host never writes them.
// [R7] The host configures everything by register accesses over the control bus.
// [R8] The host should apply one hardware reset after power-up.
// [R9] High byte sits in bits 15:8, low byte in bits 7:0 of each coefficient.
// Assumes the control-bus slave sits in front, on the same clock, already
// decoded to this page; it presents one-cycle read and write strobes.
`timescale 1ns/1ps
module ahc_coef_regs (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // Register access from the control-bus slave
   input  wire ahc_pkg::ahc_req_s req,
   // Read answer
   output logic      [7:0]       rdata_r,
   output logic                  rvalid_r,
   // Assembled coefficients to the filter datapath
   output ahc_pkg::ahc_coef_s    coef_r
);
   import ahc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Decode helpers
   function automatic logic in_bank(input logic [6:0] a);
      return (a >= OFS_LEFT_D1_HIGH) && (a <= OFS_RIGHT_D1_LOW);
   endfunction : in_bank

   function automatic logic [2:0] bank_idx(input logic [6:0] a);
      logic [6:0] d;
      d = a - OFS_LEFT_D1_HIGH;
      return d[2:0];
   endfunction : bank_idx

   // Address decode, shared by reads and writes
   wire        hit_bank = in_bank(req.addr);
   wire [2:0]  hit_idx  = bank_idx(req.addr);
   wire        wr_bank  = req.wr && hit_bank; // R6
   logic [7:0] byte_q [NUM_REGS];

   ////////////////////////////////////////////////////////////////////////////////
   // Byte storage, one register per coefficient byte
   genvar g;
   generate
      for (g = 0; g < NUM_REGS; g++) begin : g_byte
         ahc_byte_reg #(
            .RESET_VAL (RST_TABLE[g*8 +: 8]) // R2 R3 R4 R5
         ) u_byte (
            .clk   (clk),
            .rst   (rst),
            .wr_en (wr_bank && (hit_idx == 3'(g))), // R3 R4 R5
            .wdata (req.wdata),
            .q     (byte_q[g])
         );
      end
   endgenerate

   // Read mux: reserved range and anything outside the bank reads zero
   wire [7:0] rd_mux = hit_bank ? byte_q[hit_idx] : RST_RSVD; // R6

   // Coefficient assembly, high byte above low byte; one assignment drives the whole struct
   ahc_coef_s coef_nxt;
   assign coef_nxt = '{
      left_feedback_coef_one:      {byte_q[0], byte_q[1]},  // R1 R9
      right_feedforward_coef_zero: {byte_q[2], byte_q[3]},  // R1 R9
      right_feedforward_coef_one:  {byte_q[4], byte_q[5]},  // R1 R9
      right_feedback_coef_one:     {byte_q[6], byte_q[7]}}; // R1 R9

   ////////////////////////////////////////////////////////////////////////////////
   // Read answer flops; rdata_r idles at zero between reads
   wire [7:0] rdata_nxt  = req.rd ? rd_mux : 8'h00; // R6
   wire       rvalid_nxt = req.rd;
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_r  <= 8'h00;
         rvalid_r <= 1'b0;
      end else begin
         rdata_r  <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
      end
   end

   // Coefficient flops lag storage by one cycle to keep outputs registered; they load
   // the reset values directly so the filter never sees all-zero coefficients
   always_ff @(posedge clk) begin
      if (rst) begin
         coef_r <= COEF_RST; // R2 R3 R4 R5
      end else begin
         coef_r <= coef_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions
   // rst_d carries no reset of its own; it only marks the first edge after reset
   logic rst_d;
   always_ff @(posedge clk) begin
      rst_d <= rst;
   end

   // Reset values, seen at the first edge after reset falls
   reset_vals_a: assert property (@(posedge clk) rst_d && !rst |-> // R2
      coef_r.left_feedback_coef_one == 16'h537E)
      else $error("left feedback coefficient reset value wrong");

   n0_high_a: assert property (@(posedge clk) rst_d && !rst |-> // R3
      coef_r.right_feedforward_coef_zero[15:8] == 8'h39)
      else $error("right feedforward zero high byte reset value wrong");

   n1_reset_a: assert property (@(posedge clk) rst_d && !rst |-> // R4
      coef_r.right_feedforward_coef_one == 16'hF32D)
      else $error("right feedforward one reset value wrong");

   d1_low_a: assert property (@(posedge clk) rst_d && !rst |-> // R5
      coef_r.right_feedback_coef_one[7:0] == 8'h7E)
      else $error("right feedback one low byte reset value wrong");

   rsvd_zero_a: assert property (@(posedge clk) disable iff (rst) // R6
      req.rd && (req.addr >= OFS_RSVD_FIRST) |=> rvalid_r && rdata_r == 8'h00)
      else $error("reserved address did not read zero");

   write_back_a: assert property (@(posedge clk) disable iff (rst) // R4
      req.wr && req.addr == OFS_RIGHT_N1_LOW |-> ##2
      coef_r.right_feedforward_coef_one[7:0] == $past(req.wdata, 2))
      else $error("written low byte not seen on coefficient");

   high_lane_a: assert property (@(posedge clk) disable iff (rst) // R9
      req.wr && req.addr == OFS_LEFT_D1_HIGH |-> ##2
      coef_r.left_feedback_coef_one[15:8] == $past(req.wdata, 2))
      else $error("high byte not in upper lane");

   read_match_a: assert property (@(posedge clk) disable iff (rst) // R1
      req.rd && !req.wr && req.addr == OFS_RIGHT_D1_HIGH |=>
      rdata_r == coef_r.right_feedback_coef_one[15:8])
      else $error("read data disagrees with coefficient");

   ////////////////////////////////////////////////////////////////////////////////
   // Lane placement: a taken write shows on its lane two edges later, once the byte
   // has landed and the coefficient flop has copied it
   left_low_lane_a: assert property (@(posedge clk) disable iff (rst) // R9
      req.wr && req.addr == OFS_LEFT_D1_LOW |-> ##2
      coef_r.left_feedback_coef_one[7:0] == $past(req.wdata, 2))
      else $error("left feedback one low byte not in lower lane");

   n0_high_lane_a: assert property (@(posedge clk) disable iff (rst) // R3
      req.wr && req.addr == OFS_RIGHT_N0_HIGH |-> ##2
      coef_r.right_feedforward_coef_zero[15:8] == $past(req.wdata, 2))
      else $error("right feedforward zero high byte not in upper lane");

   n0_low_lane_a: assert property (@(posedge clk) disable iff (rst) // R9
      req.wr && req.addr == OFS_RIGHT_N0_LOW |-> ##2
      coef_r.right_feedforward_coef_zero[7:0] == $past(req.wdata, 2))
      else $error("right feedforward zero low byte not in lower lane");

   n1_high_lane_a: assert property (@(posedge clk) disable iff (rst) // R4
      req.wr && req.addr == OFS_RIGHT_N1_HIGH |-> ##2
      coef_r.right_feedforward_coef_one[15:8] == $past(req.wdata, 2))
      else $error("right feedforward one high byte not in upper lane");

   d1_high_lane_a: assert property (@(posedge clk) disable iff (rst) // R9
      req.wr && req.addr == OFS_RIGHT_D1_HIGH |-> ##2
      coef_r.right_feedback_coef_one[15:8] == $past(req.wdata, 2))
      else $error("right feedback one high byte not in upper lane");

   d1_low_lane_a: assert property (@(posedge clk) disable iff (rst) // R5
      req.wr && req.addr == OFS_RIGHT_D1_LOW |-> ##2
      coef_r.right_feedback_coef_one[7:0] == $past(req.wdata, 2))
      else $error("right feedback one low byte not in lower lane");

   // Read-back agrees with the assembled coefficient that holds the same byte
   left_high_read_a: assert property (@(posedge clk) disable iff (rst) // R1
      req.rd && req.addr == OFS_LEFT_D1_HIGH |=>
      rdata_r == coef_r.left_feedback_coef_one[15:8])
      else $error("read data disagrees with left feedback one high byte");

   left_low_read_a: assert property (@(posedge clk) disable iff (rst) // R1
      req.rd && req.addr == OFS_LEFT_D1_LOW |=>
      rdata_r == coef_r.left_feedback_coef_one[7:0])
      else $error("read data disagrees with left feedback one low byte");

   n0_high_read_a: assert property (@(posedge clk) disable iff (rst) // R3
      req.rd && req.addr == OFS_RIGHT_N0_HIGH |=>
      rdata_r == coef_r.right_feedforward_coef_zero[15:8])
      else $error("read data disagrees with right feedforward zero high byte");

   n0_low_read_a: assert property (@(posedge clk) disable iff (rst) // R1
      req.rd && req.addr == OFS_RIGHT_N0_LOW |=>
      rdata_r == coef_r.right_feedforward_coef_zero[7:0])
      else $error("read data disagrees with right feedforward zero low byte");

   n1_high_read_a: assert property (@(posedge clk) disable iff (rst) // R4
      req.rd && req.addr == OFS_RIGHT_N1_HIGH |=>
      rdata_r == coef_r.right_feedforward_coef_one[15:8])
      else $error("read data disagrees with right feedforward one high byte");

   n1_low_read_a: assert property (@(posedge clk) disable iff (rst) // R4
      req.rd && req.addr == OFS_RIGHT_N1_LOW |=>
      rdata_r == coef_r.right_feedforward_coef_one[7:0])
      else $error("read data disagrees with right feedforward one low byte");

   d1_low_read_a: assert property (@(posedge clk) disable iff (rst) // R5
      req.rd && req.addr == OFS_RIGHT_D1_LOW |=>
      rdata_r == coef_r.right_feedback_coef_one[7:0])
      else $error("read data disagrees with right feedback one low byte");

   ////////////////////////////////////////////////////////////////////////////////
   // Read path: an answer stands one cycle and never comes without a read, so the
   // slave in front may OR answers from several pages without extra gating
   read_valid_a: assert property (@(posedge clk) disable iff (rst) // R6
      req.rd |=> rvalid_r)
      else $error("read taken but no answer");

   idle_zero_a: assert property (@(posedge clk) disable iff (rst) // R6
      !req.rd |=> !rvalid_r && rdata_r == 8'h00)
      else $error("answer or data without a read");

   low_unmapped_a: assert property (@(posedge clk) disable iff (rst) // R6
      req.rd && req.addr < OFS_LEFT_D1_HIGH |=> rdata_r == 8'h00)
      else $error("address below the bank did not read zero");

endmodule : ahc_coef_regs

/* File: bench/ahc_host_model.sv */
// Host model standing in for the control-bus slave in front of the bank.
// Assumes calls are made just after a rising edge of clk.
`timescale 1ns/1ps
module ahc_host_model (
   // Clock
   input  wire logic       clk,
   // Register request to the bank
   output ahc_pkg::ahc_req_s req
);
   import ahc_pkg::*;

   initial req = '0;

   // One request per call, held over one rising edge; a following call replaces it,
   // so no line is written twice in one time step
   task automatic xfer(input logic w, input logic r, input logic [6:0] a, input logic [7:0] d);
      req = '{wr: w, rd: r, addr: a, wdata: d};
      @(posedge clk);
      #1;
   endtask : xfer

   // Released lines show the inverse so stale values are never mistaken for live ones
   task automatic idle();
      req = '{wr: 1'b0, rd: 1'b0, addr: ~req.addr, wdata: ~req.wdata};
   endtask : idle
endmodule : ahc_host_model

/* File: bench/ahc_coef_regs_tb.sv */
// Self-checking bench for the coefficient register bank.
// Assumes the host model drives every request; reads are scored from a queue.
`timescale 1ns/1ps
module ahc_coef_regs_tb;
   import ahc_pkg::*;
   logic       clk;
   logic       rst;
   ahc_req_s   req;
   logic [7:0] rdata_r;
   logic       rvalid_r;
   ahc_coef_s  coef_r;
   logic [7:0] exp_q[$];
   logic [7:0] model [8] = '{8'h53, 8'h7E, 8'h39, 8'h00, 8'hF3, 8'h2D, 8'h00, 8'h7E};
   int         n_mismatch = 0;
   int         tests_run = 0;
   integer     seed = 32'h9b4f7b97;

   ahc_host_model host (.clk(clk), .req(req));
   ahc_coef_regs DUT (.clk(clk), .rst(rst), .req(req), .rdata_r(rdata_r),
                      .rvalid_r(rvalid_r), .coef_r(coef_r));

   ////////////////////////////////////////////////////////////////////////////////
   // Clock, watchdog and scoring
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // Whole run needs some 110 cycles; this leaves wide margin
   initial begin
      #(1000 * 50);
      n_mismatch++;
      tally_and_finish();
   end

   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic tally_and_finish();
      if (n_mismatch == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : tally_and_finish

   function automatic logic [63:0] coef_exp();
      return {model[0], model[1], model[2], model[3], model[4], model[5], model[6], model[7]};
   endfunction : coef_exp

   // Oldest noted read is compared whenever an answer appears
   always @(posedge clk) begin
      if (rvalid_r === 1'b1) check("read data", rdata_r, exp_q.pop_front());
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Stimulus: a read notes the old value, so a same-cycle write is seen afterwards
   task automatic acc(input logic w, input logic r, input int a, input logic [7:0] d);
      logic hit;
      hit = (a >= 'h45 && a <= 'h4C);
      if (r) exp_q.push_back(hit ? model[a - 'h45] : 8'h00);
      if (w && hit) model[a - 'h45] = d;
      host.xfer(w, r, a[6:0], d);
   endtask : acc

   initial begin
      rst = 1'b1;
      repeat (20) @(posedge clk);
      #1 rst = 1'b0;
      check("coef reset", coef_r, coef_exp());
      // Reset values and read-only zero range, from the last outside address on
      for (int a = 'h44; a <= 'h7F; a++) acc(1'b0, 1'b1, a, 8'h00);
      // Back-to-back random writes, one with a same-cycle read
      for (int i = 0; i < 8; i++) acc(1'b1, i == 2, 'h45 + i, 8'($random(seed)));
      // Writes outside the bank are dropped; the reserved range is never written
      acc(1'b1, 1'b0, 'h44, 8'hA5);
      acc(1'b1, 1'b0, 'h00, 8'h5A);
      check("coef after writes", coef_r, coef_exp());
      // Mid-run reset after writes brings every byte back to its reset value
      host.idle();
      rst = 1'b1;
      repeat (2) @(posedge clk);
      #1 rst = 1'b0;
      model = '{RST_LEFT_D1_HIGH, RST_LEFT_D1_LOW, RST_RIGHT_N0_HIGH, RST_RIGHT_N0_LOW,
                RST_RIGHT_N1_HIGH, RST_RIGHT_N1_LOW, RST_RIGHT_D1_HIGH, RST_RIGHT_D1_LOW};
      check("coef mid reset", coef_r, coef_exp());
      for (int i = 0; i < 4; i++) acc(1'b1, 1'b0, 'h49 + i, 8'($random(seed)) | 8'h80);
      for (int a = 'h44; a <= 'h4E; a++) acc(1'b0, 1'b1, a, 8'h00);
      acc(1'b0, 1'b1, 'h7F, 8'h00);
      host.idle();
      repeat (3) @(posedge clk);
      #1;
      check("coef final", coef_r, coef_exp());
      check("pending reads", 64'(exp_q.size()), 64'h0);
      tally_and_finish();
   end
endmodule : ahc_coef_regs_tb
